// file: bench/core_sequencer_model.sv
`timescale 1ns/100ps
module core_sequencer_model (
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Pacing
  input  wire [2:0] ackDelay,
  // Interrupt link
  input  wire       intRequest,
  output reg        intAck
);
  reg [2:0] waitCnt_reg;
  // Accept the machine cycle after the chosen delay
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intAck      <= 1'b0;
      waitCnt_reg <= 3'h0;
    end else if (intAck) begin
      intAck      <= 1'b0;
      waitCnt_reg <= 3'h0;
    end else if (intRequest) begin
      if (waitCnt_reg >= ackDelay) intAck <= 1'b1;
      waitCnt_reg <= waitCnt_reg + 3'h1;
    end
  end
endmodule // core_sequencer_model

// file: bench/irq_unit_assertions.sv
`timescale 1ns/100ps
module irq_unit_checker (
  // Clock and reset
  input wire        clk,
  input wire        reset_n,
  // Bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  // Core link
  input wire        intAck,
  input wire        intRequest,
  input wire [2:0]  grantLine,
  input wire [7:0]  vectorLowAddr,
  input wire [7:0]  vectorHighAddr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Handshake steps
  // ----------------------------------------------------------------
  sequence writeTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence readTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence ackTaken;
    intRequest && intAck;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_grant_range: assert property (
    intRequest |-> grantLine <= 3'h5)
    else $error("grant line out of range");
  chk_vector_pair: assert property (
    $rose(intRequest) |-> vectorLowAddr == {4'h0, grantLine, 1'b0})
    else $error("vector does not match granted line");
  chk_vector_word: assert property (
    intRequest |-> vectorHighAddr == vectorLowAddr + 8'h01)
    else $error("vector bytes not consecutive");
  chk_request_stands: assert property (
    intRequest && !intAck |=> intRequest && $stable(grantLine))
    else $error("request dropped before acknowledge");
  chk_ack_drops: assert property (
    ackTaken |=> !intRequest [*2])
    else $error("request stays after acknowledge");
  chk_write_answer: assert property (
    writeTaken |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (
    readTaken |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_read_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  chk_reset_idle: assert property (
    $rose(reset_n) |-> !intRequest && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
endmodule // irq_unit_checker

bind six_source_vectored_interrupt_unit irq_unit_checker chk (
  .clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .intAck, .intRequest, .grantLine,
  .vectorLowAddr, .vectorHighAddr);

// file: bench/tb_top.sv
`timescale 1ns/100ps
`include "irq_unit_consts.vh"
module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic [11:0] PRI = {`PRIORITY_ORDER_INDEX, 2'h0};
  localparam logic [11:0] REQ = {`INTERRUPT_REQUEST_INDEX, 2'h0};
  localparam logic [11:0] MSK = {`REQUEST_MASK_INDEX, 2'h0};
  localparam logic [11:0] SRC = {`SOURCE_SELECT_INDEX, 2'h0};
  localparam logic [15:0] EVT [12] = '{16'h0010, 16'h1801, 16'h2201,
    16'h2A0F, 16'h3101, 16'h3021, 16'h300F, 16'h4003, 16'h5004,
    16'h6005, 16'h7002, 16'h8000};
  logic        clk = 1'b0, reset_n = 1'b0, enablePulse = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [2:0]  pin = 3'h7, ackDelay = 3'h3, w;
  logic [8:0]  evt = 9'h000;
  logic [3:0]  ev, ln;
  logic [7:0]  p, e;
  logic [5:0]  f, m;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, intRequest, intAck;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [2:0]   grantLine;
  wire [7:0]   vectorLowAddr, vectorHighAddr;
  int          nMismatch = 0, cmpCount = 0, j, c;

  six_source_vectored_interrupt_unit dut (.clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port3LineOnePin(pin[0]), .port3LineTwoPin(pin[1]),
    .port3LineThreePin(pin[2]), .rxEvent(evt[0]), .txEvent(evt[1]),
    .baudEvent(evt[2]), .recoveryEvent(evt[3]), .timer16Event(evt[4]),
    .timer8Event(evt[5]), .lowVoltageEvent(evt[6]),
    .analogInputOneEvent(evt[7]), .analogInputTwoEvent(evt[8]),
    .enableInterruptsInstruction(enablePulse), .intAck, .intRequest,
    .grantLine, .vectorLowAddr, .vectorHighAddr);
  core_sequencer_model core (.clk, .reset_n, .ackDelay, .intRequest,
    .intAck);

  // Free-running clock
  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic finalReport;
    if (nMismatch == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timedOut;
    nMismatch++;
    $display("CHECK FAILED %0t wait timed out", $time);
    finalReport();
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er = `RESP_OKAY);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) timedOut();
    check(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er = `RESP_OKAY);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) timedOut();
    check(s_axi_rresp, er);
    check(s_axi_rdata, {24'h000000, d});
    s_axi_rready <= 1'b0;
  endtask
  task automatic waitHigh(input bit ack);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (ack ? intAck : intRequest) break;
    end
    if (i == 60) timedOut();
  endtask
  task automatic pulse(input logic [3:0] k);
    @(posedge clk) evt <= 9'h001 << k;
    @(posedge clk) evt <= 9'h000;
  endtask
  task automatic grantCheck(input logic [2:0] g);
    waitHigh(1'b0);
    check(grantLine, g);
    check({vectorHighAddr, vectorLowAddr}, {4'h0, g, 1'b1, 4'h0, g, 1'b0});
    waitHigh(1'b1);
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Expectation functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] edgeExp(input logic [1:0] s, input bit up);
    logic [7:0] r;
    r = {s, 6'h00};
    r[2] = up ? s[1] : (!s[1] | s[0]);
    r[1] = !up;
    r[0] = up ? s[0] : (!s[0] | s[1]);
    return r;
  endfunction
  function automatic logic [2:0] pick(input logic [7:0] q,
                                      input logic [5:0] g);
    logic [5:0] ord, hl;
    int k;
    case ({q[4], q[3], q[0]})
      3'h1: ord = 6'h21;
      3'h3: ord = 6'h09;
      3'h4: ord = 6'h18;
      3'h5: ord = 6'h24;
      3'h6: ord = 6'h12;
      default: ord = 6'h06;
    endcase
    for (k = 2; k >= 0; k--) begin
      case (ord[2*k +: 2])
        2'h0: hl = q[5] ? 6'h1D : 6'h2B;
        2'h1: hl = q[2] ? 6'h02 : 6'h10;
        default: hl = q[1] ? 6'h21 : 6'h0C;
      endcase
      if (g[hl[5:3]]) return hl[5:3];
      if (g[hl[2:0]]) return hl[2:0];
    end
    return 3'h7;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hC441));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(PRI, 8'h00);
    rd(REQ, 8'h00);
    rd(MSK, 8'h00);
    rd(SRC, 8'h00);
    rd(12'h000, 8'h00, `RESP_SLVERR);
    wr(12'h000, 8'hFF, `RESP_SLVERR);
    wr(REQ, 8'h3F);
    rd(REQ, 8'h00);
    @(posedge clk) enablePulse <= 1'b1;
    @(posedge clk) enablePulse <= 1'b0;
    wr(REQ, 8'h15);
    rd(REQ, 8'h15);
    foreach (EVT[i]) begin
      ev = EVT[i][15:12];
      ln = EVT[i][3:0];
      e = (ln == 4'hF) ? 8'h00 : 8'h01 << ln;
      wr(SRC, EVT[i][11:4]);
      wr(REQ, 8'h00);
      wr(MSK, 8'hBF & ~e);
      pulse(ev);
      repeat (4) @(posedge clk);
      check(intRequest, 1'b0);
      rd(REQ, e);
      if (ln != 4'hF) begin
        wr(MSK, 8'h80 | e);
        grantCheck(ln[2:0]);
        rd(REQ, 8'h00);
        rd(MSK, e);
      end
    end
    wr(SRC, 8'h00);
    wr(MSK, 8'h00);
    for (c = 0; c < 5; c++) begin
      wr(SRC, (c == 4) ? 8'h01 : 8'h00);
      wr(REQ, {c[1:0] | {2{c[2]}}, 6'h00});
      @(posedge clk) pin <= 3'h0;
      repeat (6) @(posedge clk);
      rd(REQ, edgeExp(c[1:0] | {2{c[2]}}, 1'b0) & ~{7'h0, c[2]});
      wr(REQ, {c[1:0] | {2{c[2]}}, 6'h00});
      @(posedge clk) pin <= 3'h7;
      repeat (6) @(posedge clk);
      rd(REQ, edgeExp(c[1:0] | {2{c[2]}}, 1'b1) & ~{7'h0, c[2]});
    end
    wr(SRC, 8'h00);
    for (j = 0; j < 24; j++) begin
      p = (j < 2) ? (j ? 8'h08 : 8'h01) : 8'($urandom) & 8'h3F;
      f = (j < 2) ? 6'h23 : 6'($urandom_range(1, 63));
      m = (j < 2) ? 6'h3F : 6'($urandom_range(1, 63));
      ackDelay <= 3'($urandom_range(2, 6));
      wr(PRI, p);
      wr(MSK, 8'h00);
      wr(REQ, {2'h0, f});
      wr(MSK, {2'h2, m});
      if ((f & m) == 6'h00) begin
        repeat (6) @(posedge clk);
        check(intRequest, 1'b0);
      end else begin
        w = pick(p, f & m);
        grantCheck(w);
        rd(REQ, {2'h0, f & ~(6'h01 << w)});
      end
    end
    finalReport();
  end
endmodule // tb_top

// file: src/irq_priority_picker.v
`timescale 1ns/100ps
`include "irq_unit_consts.vh"

module irq_priority_picker (
  // Pending requests and ordering
  input  wire [5:0] pending,
  input  wire [7:0] priorityOrder,
  // Winner
  output reg        winValid,
  output reg  [2:0] winLine
);

  // Higher ranked of a pair: {valid, line}
  function [3:0] pickPair;
    input       pendHi;
    input [2:0] lineHi;
    input       pendLo;
    input [2:0] lineLo;
    begin
      if (pendHi)
        pickPair = {1'b1, lineHi};
      else if (pendLo)
        pickPair = {1'b1, lineLo};
      else
        pickPair = 4'h0;
    end
  endfunction

  wire [3:0] grpA;
  wire [3:0] grpB;
  wire [3:0] grpC;
  reg  [3:0] first;
  reg  [3:0] second;
  reg  [3:0] third;

  // Winner within each group
  assign grpA = priorityOrder[`PRIO_GROUP_A_SWAP] ?
    pickPair(pending[3], `REQ_LINE_THREE, pending[5], `REQ_LINE_FIVE) :
    pickPair(pending[5], `REQ_LINE_FIVE, pending[3], `REQ_LINE_THREE);
  assign grpB = priorityOrder[`PRIO_GROUP_B_SWAP] ?
    pickPair(pending[0], `REQ_LINE_ZERO, pending[2], `REQ_LINE_TWO) :
    pickPair(pending[2], `REQ_LINE_TWO, pending[0], `REQ_LINE_ZERO);
  assign grpC = priorityOrder[`PRIO_GROUP_C_SWAP] ?
    pickPair(pending[4], `REQ_LINE_FOUR, pending[1], `REQ_LINE_ONE) :
    pickPair(pending[1], `REQ_LINE_ONE, pending[4], `REQ_LINE_FOUR);

  // Group ordering and final choice
  always @* begin
    case ({priorityOrder[4:3], priorityOrder[0]})
      3'h1: begin first = grpC; second = grpA; third = grpB; end
      3'h2: begin first = grpA; second = grpB; third = grpC; end
      3'h3: begin first = grpA; second = grpC; third = grpB; end
      3'h4: begin first = grpB; second = grpC; third = grpA; end
      3'h5: begin first = grpC; second = grpB; third = grpA; end
      3'h6: begin first = grpB; second = grpA; third = grpC; end
      default: begin first = grpA; second = grpB; third = grpC; end
    endcase
    if (first[3]) begin
      winValid = 1'b1;
      winLine  = first[2:0];
    end else if (second[3]) begin
      winValid = 1'b1;
      winLine  = second[2:0];
    end else begin
      winValid = third[3];
      winLine  = third[2:0];
    end
  end

endmodule // irq_priority_picker

// file: src/irq_unit_consts.vh
`ifndef IRQ_UNIT_CONSTS_VH
`define IRQ_UNIT_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PRIORITY_ORDER_INDEX     10'h0F9
`define INTERRUPT_REQUEST_INDEX  10'h0FA
`define REQUEST_MASK_INDEX       10'h0FB
`define SOURCE_SELECT_INDEX      10'h0FC
`define ADDR_W                   12

// ----------------------------------------------------------------
// Decoded register selections
// ----------------------------------------------------------------
`define SEL_NONE                 3'h0
`define SEL_PRIORITY             3'h1
`define SEL_REQUEST              3'h2
`define SEL_MASK                 3'h3
`define SEL_SOURCE               3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define REQ_EDGE_LINE_TWO        7
`define REQ_EDGE_LINE_ZERO       6
`define MASK_MASTER              7
`define PRIO_GROUP_A_SWAP        5
`define PRIO_GROUP_B_SWAP        2
`define PRIO_GROUP_C_SWAP        1
`define SRC_TX_SELECT            7
`define SRC_BAUD_SELECT          5
`define SRC_RECOVERY_ENABLE      4
`define SRC_ANALOG_MODE          1
`define SRC_RX_ENABLE            0

// ----------------------------------------------------------------
// Request line numbers
// ----------------------------------------------------------------
`define REQ_LINE_ZERO            3'd0
`define REQ_LINE_ONE             3'd1
`define REQ_LINE_TWO             3'd2
`define REQ_LINE_THREE           3'd3
`define REQ_LINE_FOUR            3'd4
`define REQ_LINE_FIVE            3'd5

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define REQUEST_RESET            8'h00
`define MASK_RESET               8'h00
`define PRIORITY_RESET           8'h00
`define SOURCE_RESET             8'h00
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

// file: src/six_source_vectored_interrupt_unit.v
// How it works
// - Six maskable, prioritised request lines to core
// - Line zero from pin or receiver
// - Serial side: transmit, else baud event
// - Line one: pin, or recovery logic
// - Pins, two timers, low-voltage feed lines
// - Mask register enables globally and individually
// - Line n vectors through bytes 2n, 2n+1
// - Line one pin triggers on falling edge
// - Lines two, zero: rising, falling or both
// - Request bits 7:6 choose the edges
// - Analog inputs map to lines two, zero
// - Programmable priority encoder picks one request
// - Grant starts cycle, disables further interrupts
// - Vector pair holds sixteen-bit routine address
// - Flags latch even while masked, pollable
// - Service clears flag; software sets or clears
// - Priority bits order groups and pairs
// - Master enable bit resets to zero
// - Request writes ignored until enable executed
`timescale 1ns/100ps
`include "irq_unit_consts.vh"

module six_source_vectored_interrupt_unit (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Port 3 pins
  input  wire        port3LineOnePin,
  input  wire        port3LineTwoPin,
  input  wire        port3LineThreePin,
  // Internal event pulses
  input  wire        rxEvent,
  input  wire        txEvent,
  input  wire        baudEvent,
  input  wire        recoveryEvent,
  input  wire        timer16Event,
  input  wire        timer8Event,
  input  wire        lowVoltageEvent,
  input  wire        analogInputOneEvent,
  input  wire        analogInputTwoEvent,
  // Processor core
  input  wire        enableInterruptsInstruction,
  input  wire        intAck,
  output wire        intRequest,
  output reg  [2:0]  grantLine,
  output reg  [7:0]  vectorLowAddr,
  output reg  [7:0]  vectorHighAddr
);

  localparam IDLE    = 1'b0;
  localparam GRANTED = 1'b1;

  // Register address decode
  function [2:0] decodeSel;
    input [11:0] addr;
    begin
      case (addr[11:2])
        `PRIORITY_ORDER_INDEX:    decodeSel = `SEL_PRIORITY;
        `INTERRUPT_REQUEST_INDEX: decodeSel = `SEL_REQUEST;
        `REQUEST_MASK_INDEX:      decodeSel = `SEL_MASK;
        `SOURCE_SELECT_INDEX:     decodeSel = `SEL_SOURCE;
        default:                  decodeSel = `SEL_NONE;
      endcase
    end
  endfunction

  reg  [7:0]  priorityOrder_reg;
  reg  [7:0]  interruptRequest_reg;
  reg  [7:0]  interruptRequest_next;
  reg  [7:0]  requestMask_reg;
  reg  [7:0]  requestMask_next;
  reg  [7:0]  sourceSelect_reg;
  reg         unlocked_reg;
  reg         state_reg;
  reg  [2:0]  pinSync1_reg;
  reg  [2:0]  pinSync2_reg;
  reg  [2:0]  pinLast_reg;
  reg  [5:0]  hwSet_reg;
  reg  [5:0]  hwSet_next;
  reg         awHeld_reg;
  reg  [11:0] awAddr_reg;
  reg         wHeld_reg;
  reg  [7:0]  wData_reg;
  reg         wLane_reg;
  wire        doWrite;
  wire [2:0]  writeSel;
  wire        laneWrite;
  wire [2:0]  pinRise;
  wire [2:0]  pinFall;
  wire        edgeTwoRise;
  wire        edgeZeroRise;
  wire        edgeZeroFall;
  wire        edgeTwoFall;
  wire [5:0]  pending;
  wire        winValid;
  wire [2:0]  winLine;
  wire        serviceDone;
  reg  [31:0] readData;

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------

  // Address and data may arrive in either order
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign doWrite       = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign writeSel      = decodeSel(awAddr_reg);
  assign laneWrite     = doWrite && wLane_reg;

  // Capture address, data and answer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_reg   <= 1'b0;
      awAddr_reg   <= 12'h000;
      wHeld_reg    <= 1'b0;
      wData_reg    <= 8'h00;
      wLane_reg    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata[7:0];
        wLane_reg <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (writeSel == `SEL_NONE) ? `RESP_SLVERR
                                                : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------

  assign s_axi_arready = !s_axi_rvalid;

  // Read mux; priority register is write-only
  always @* begin
    case (decodeSel(s_axi_araddr))
      `SEL_REQUEST: readData = {24'h000000, interruptRequest_reg};
      `SEL_MASK:    readData = {24'h000000, requestMask_reg[7],
                                1'b0, requestMask_reg[5:0]};
      `SEL_SOURCE:  readData = {24'h000000, sourceSelect_reg};
      default:      readData = 32'h00000000;
    endcase
  end

  // Registered read answer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= readData;
      s_axi_rresp  <= (decodeSel(s_axi_araddr) == `SEL_NONE) ?
                      `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------

  // Two flops, then a third for edge history
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync1_reg <= 3'h0;
      pinSync2_reg <= 3'h0;
      pinLast_reg  <= 3'h0;
    end else begin
      pinSync1_reg <= {port3LineThreePin, port3LineTwoPin,
                       port3LineOnePin};
      pinSync2_reg <= pinSync1_reg;
      pinLast_reg  <= pinSync2_reg;
    end
  end

  assign pinRise = pinSync2_reg & ~pinLast_reg;
  assign pinFall = ~pinSync2_reg & pinLast_reg;

  // Edge choice for line two (pin one) and line zero (pin two)
  assign edgeTwoRise  = interruptRequest_reg[`REQ_EDGE_LINE_TWO];
  assign edgeTwoFall  = !interruptRequest_reg[`REQ_EDGE_LINE_TWO] ||
                        interruptRequest_reg[`REQ_EDGE_LINE_ZERO];
  assign edgeZeroRise = interruptRequest_reg[`REQ_EDGE_LINE_ZERO];
  assign edgeZeroFall = !interruptRequest_reg[`REQ_EDGE_LINE_ZERO] ||
                        interruptRequest_reg[`REQ_EDGE_LINE_TWO];

  // ----------------------------------------------------------------
  // Source routing
  // ----------------------------------------------------------------

  // Hardware set events for each line
  always @* begin
    hwSet_next = 6'h00;
    if (sourceSelect_reg[`SRC_RX_ENABLE])
      hwSet_next[0] = rxEvent;
    else
      hwSet_next[0] = (edgeZeroRise && pinRise[1]) ||
                      (edgeZeroFall && pinFall[1]);
    hwSet_next[0] = hwSet_next[0] || analogInputTwoEvent;
    if (sourceSelect_reg[`SRC_TX_SELECT])
      hwSet_next[1] = txEvent;
    else if (sourceSelect_reg[`SRC_BAUD_SELECT])
      hwSet_next[1] = baudEvent;
    else if (sourceSelect_reg[`SRC_ANALOG_MODE] ||
             sourceSelect_reg[`SRC_RECOVERY_ENABLE])
      hwSet_next[1] = recoveryEvent;
    else
      hwSet_next[1] = pinFall[2];
    hwSet_next[2] = (edgeTwoRise && pinRise[0]) ||
                    (edgeTwoFall && pinFall[0]) ||
                    analogInputOneEvent;
    hwSet_next[3] = timer16Event;
    hwSet_next[4] = timer8Event;
    hwSet_next[5] = lowVoltageEvent;
  end

  // Detected events land in flags two cycles later
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      hwSet_reg <= 6'h00;
    else
      hwSet_reg <= hwSet_next;
  end

  // ----------------------------------------------------------------
  // Request, mask, priority and source registers
  // ----------------------------------------------------------------

  assign serviceDone = (state_reg == GRANTED) && intAck;

  // Request flags: write, service clear, hardware set wins
  always @* begin
    interruptRequest_next = interruptRequest_reg;
    if (laneWrite && writeSel == `SEL_REQUEST && unlocked_reg)
      interruptRequest_next = wData_reg;
    if (serviceDone)
      interruptRequest_next[grantLine] = 1'b0;
    interruptRequest_next[5:0] = interruptRequest_next[5:0] |
                                 hwSet_reg;
  end

  // Master enable: enable instruction sets, acknowledge clears
  always @* begin
    requestMask_next = requestMask_reg;
    if (laneWrite && writeSel == `SEL_MASK)
      requestMask_next = {wData_reg[7], 1'b0, wData_reg[5:0]};
    if (enableInterruptsInstruction)
      requestMask_next[`MASK_MASTER] = 1'b1;
    if (serviceDone)
      requestMask_next[`MASK_MASTER] = 1'b0;
  end

  // Register storage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interruptRequest_reg <= `REQUEST_RESET;
      requestMask_reg      <= `MASK_RESET;
      priorityOrder_reg    <= `PRIORITY_RESET;
      sourceSelect_reg     <= `SOURCE_RESET;
      unlocked_reg         <= 1'b0;
    end else begin
      interruptRequest_reg <= interruptRequest_next;
      requestMask_reg      <= requestMask_next;
      if (laneWrite && writeSel == `SEL_PRIORITY)
        priorityOrder_reg <= {2'b00, wData_reg[5:0]};
      if (laneWrite && writeSel == `SEL_SOURCE)
        sourceSelect_reg <= wData_reg;
      if (enableInterruptsInstruction)
        unlocked_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration and interrupt machine cycle
  // ----------------------------------------------------------------

  // Enabled requests compete only with master enable set
  assign pending = interruptRequest_reg[5:0] & requestMask_reg[5:0] &
                   {6{requestMask_reg[`MASK_MASTER]}};

  irq_priority_picker picker (
    .pending       (pending),
    .priorityOrder (priorityOrder_reg),
    .winValid      (winValid),
    .winLine       (winLine)
  );

  assign intRequest = (state_reg == GRANTED);

  // Grant latches line and vector byte pair
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= IDLE;
      grantLine      <= 3'h0;
      vectorLowAddr  <= 8'h00;
      vectorHighAddr <= 8'h00;
    end else begin
      case (state_reg)
        IDLE: begin
          if (winValid) begin
            state_reg      <= GRANTED;
            grantLine      <= winLine;
            vectorLowAddr  <= {4'h0, winLine, 1'b0};
            vectorHighAddr <= {4'h0, winLine, 1'b1};
          end
        end
        GRANTED: begin
          if (intAck)
            state_reg <= IDLE;
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

endmodule // six_source_vectored_interrupt_unit
